// ===== design/orl_otp_row_and_sector_lock.sv
// serial command handler for the one-time information rows and sector lock
// assumes pins arrive asynchronously; lock and protect inputs come from core logic
//
// Operation
// - program opcode, address, 1-256 bytes captured
// - program starts only on chip select rise
// - while programming only status read accepted
// - busy flag readable by status read
// - over 256 bytes keeps last 256
// - byte address wraps within the page
// - unwritten page bytes stay unchanged
// - each row programmable only once
// - read: opcode, address, one dummy byte
// - data shifted out on falling clock edges
// - read address increments after each byte
// - data past row end is undefined
// - chip select high ends read output
// - read ignored while any cycle busy
// - open takes address, low 12 bits ignored
// - open effective only with block protection
// - one open sector, newest replaces old
// - close relocks the open sector
// - four rows at mid byte 00/10/20/30
// - row lock bits forbid programming

module orl_otp_row_and_sector_lock
    import orl_pkg::*;
(
    input wire logic i_core_clk, // core clock, 100 MHz
    input wire logic i_rst, // synchronous reset, active high
    input wire logic i_cs_n, // chip select pin, active low
    input wire logic i_sck, // serial clock pin
    input wire logic i_si, // serial data in pin
    input wire logic i_ext_busy, // erase/program/register write busy elsewhere
    input wire logic [3:0] i_block_protect, // block protect bits 3..0
    input wire logic [3:0] i_row_lock, // row lock bits, one per row
    output logic o_so, // serial data out
    output logic o_so_oe, // serial out enable, high while driven
    output logic o_busy_flag, // row program in progress
    output logic o_write_latch, // write latch state
    output logic o_sector_open_valid, // one sector is open
    output logic [11:0] o_sector_open_addr, // open sector, address bits 23..12
    output logic [3:0] o_row_programmed // row already programmed
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic si_s1;
        logic si_s2;
        orl_spi_e st;
        logic [7:0] opc;
        logic [5:0] cnt;
        logic [7:0] sh_in;
        logic [23:0] addr;
        logic [7:0] sh_out;
        logic so;
        logic so_oe;
        logic got_data;
        logic past_end;
        logic [7:0] ptr;
        logic [ROW_BYTES-1:0] mask;
        logic [ROW_BYTES-1:0][7:0] pbuf;
        logic [ROWS*ROW_BYTES-1:0][7:0] mem;
        logic [3:0] row_done;
        logic [1:0] prog_row;
        logic busy;
        logic [15:0] busy_cnt;
        logic latch;
        logic sec_valid;
        logic [11:0] sec_addr;
    } orl_state_s;

    orl_state_s s;
    orl_state_s next_s;

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    function automatic logic row_ok(input logic [23:0] a);
        row_ok = (a[23:16] == ROW_HIGH_BYTE) && ((a[15:8] & ROW_MID_MASK) == 8'h00);
    endfunction

    function automatic logic [5:0] data_start(input logic [7:0] op);
        case (op)
            CMD_OTP_ROW_READ: data_start = READ_DATA_START;
            CMD_OTP_ROW_PROGRAM: data_start = PROG_DATA_START;
            CMD_SECTOR_OPEN: data_start = PROG_DATA_START;
            default: data_start = STATUS_DATA_START;
        endcase
    endfunction

    function automatic logic known_cmd(input logic [7:0] op);
        known_cmd = (op == CMD_WRITE_PERMIT) || (op == CMD_STATUS_READ) ||
            (op == CMD_OTP_ROW_PROGRAM) || (op == CMD_OTP_ROW_READ) ||
            (op == CMD_SECTOR_OPEN) || (op == CMD_SECTOR_CLOSE);
    endfunction

    // edges seen on the second and third sync stages only
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] sh_new;
    logic [7:0] opc_new;
    logic [7:0] byte_out;
    logic [1:0] row_sel;

    assign cs_rise = s.cs_s2 & ~s.cs_s3;
    assign cs_fall = ~s.cs_s2 & s.cs_s3;
    assign sck_rise = s.sck_s2 & ~s.sck_s3 & ~s.cs_s2;
    assign sck_fall = ~s.sck_s2 & s.sck_s3 & ~s.cs_s2;
    assign sh_new = {s.sh_in[6:0], s.si_s2};
    assign opc_new = sh_new;
    assign row_sel = s.addr[13:12];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        byte_out = UNDEF_BYTE;
        next_s.cs_s1 = i_cs_n;
        next_s.cs_s2 = s.cs_s1;
        next_s.cs_s3 = s.cs_s2;
        next_s.sck_s1 = i_sck;
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_s3 = s.sck_s2;
        next_s.si_s1 = i_si;
        next_s.si_s2 = s.si_s1;

        // serial side
        if (cs_fall) begin
            next_s.st = SP_OPCODE;
            next_s.cnt = 6'h00;
            next_s.got_data = 1'b0;
            next_s.past_end = 1'b0;
            // page buffer is still being burned while busy
            if (!s.busy) begin
                next_s.mask = '0;
            end
        end else if (sck_rise) begin
            next_s.sh_in = sh_new;
            case (s.st)
                SP_OPCODE: begin
                    next_s.cnt = 6'(s.cnt + 6'h01);
                    if (s.cnt == OPC_LAST_BIT) begin
                        next_s.opc = opc_new;
                        if (s.busy && opc_new != CMD_STATUS_READ) begin
                            next_s.st = SP_IGNORE;
                        end else if (opc_new == CMD_OTP_ROW_READ && i_ext_busy) begin
                            next_s.st = SP_IGNORE;
                        end else if (known_cmd(opc_new)) begin
                            next_s.st = SP_RUN;
                        end else begin
                            next_s.st = SP_IGNORE;
                        end
                    end
                end
                SP_RUN: begin
                    if (s.cnt[2:0] == 3'h7 && s.cnt >= data_start(s.opc)) begin
                        next_s.cnt = data_start(s.opc);
                    end else begin
                        next_s.cnt = 6'(s.cnt + 6'h01);
                    end
                    if (s.cnt <= ADDR_LAST_BIT) begin
                        next_s.addr = {s.addr[22:0], s.si_s2};
                    end
                    if (s.opc == CMD_OTP_ROW_PROGRAM) begin
                        if (s.cnt == ADDR_LAST_BIT) begin
                            next_s.ptr = {s.addr[6:0], s.si_s2};
                        end
                        if (s.cnt >= PROG_DATA_START && s.cnt[2:0] == 3'h7) begin
                            next_s.pbuf[s.ptr] = sh_new;
                            next_s.mask[s.ptr] = 1'b1;
                            next_s.ptr = 8'(s.ptr + 8'h01);
                            next_s.got_data = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (sck_fall && s.st == SP_RUN) begin
            if ((s.opc == CMD_STATUS_READ || s.opc == CMD_OTP_ROW_READ) &&
                s.cnt >= data_start(s.opc)) begin
                if (s.cnt[2:0] == 3'h0) begin
                    if (s.opc == CMD_STATUS_READ) begin
                        byte_out = 8'h00;
                        byte_out[STATUS_BUSY_BIT] = s.busy;
                        byte_out[STATUS_LATCH_BIT] = s.latch;
                    end else begin
                        if (!s.past_end && row_ok(s.addr)) begin
                            byte_out = s.mem[{row_sel, s.addr[7:0]}];
                        end else begin
                            byte_out = UNDEF_BYTE;
                        end
                        next_s.addr[7:0] = 8'(s.addr[7:0] + 8'h01);
                        if (s.addr[7:0] == LAST_BYTE) begin
                            next_s.past_end = 1'b1;
                        end
                    end
                    next_s.so = byte_out[7];
                    next_s.sh_out = {byte_out[6:0], 1'b0};
                    next_s.so_oe = 1'b1;
                end else begin
                    next_s.so = s.sh_out[7];
                    next_s.sh_out = {s.sh_out[6:0], 1'b0};
                end
            end
        end

        // command end
        if (cs_rise) begin
            next_s.st = SP_IDLE;
            next_s.so_oe = 1'b0;
            if (s.st == SP_RUN) begin
                case (s.opc)
                    CMD_WRITE_PERMIT: begin
                        if (s.cnt == STATUS_DATA_START) begin
                            next_s.latch = 1'b1;
                        end
                    end
                    CMD_OTP_ROW_PROGRAM: begin
                        next_s.latch = 1'b0;
                        if (s.latch && s.got_data && row_ok(s.addr) &&
                            !i_row_lock[row_sel] && !s.row_done[row_sel]) begin
                            next_s.busy = 1'b1;
                            next_s.busy_cnt = PROG_CYCLES;
                            next_s.prog_row = row_sel;
                        end
                    end
                    CMD_SECTOR_OPEN: begin
                        if (s.cnt >= PROG_DATA_START && i_block_protect != 4'h0) begin
                            next_s.sec_valid = 1'b1;
                            next_s.sec_addr = s.addr[23:12];
                        end
                    end
                    CMD_SECTOR_CLOSE: begin
                        next_s.sec_valid = 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (s.cs_s2 && !cs_rise) begin
            next_s.so_oe = 1'b0;
        end

        // internal program: only captured bytes touch the row
        if (s.busy) begin
            next_s.busy_cnt = 16'(s.busy_cnt - 16'h0001);
            if (s.busy_cnt == 16'h0001) begin
                for (int b = 0; b < ROW_BYTES; b++) begin
                    if (s.mask[b]) begin
                        next_s.mem[{s.prog_row, 8'(b)}] = s.pbuf[b];
                    end
                end
                next_s.row_done[s.prog_row] = 1'b1;
                next_s.busy = 1'b0;
            end
        end

        // reset comes last so that it overrides every update above
        if (i_rst) begin
            next_s = '0;
            next_s.st = SP_IDLE;
            next_s.cs_s1 = 1'b1;
            next_s.cs_s2 = 1'b1;
            next_s.cs_s3 = 1'b1;
            for (int m = 0; m < ROWS * ROW_BYTES; m++) begin
                next_s.mem[m] = ERASED_BYTE;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        s <= next_s;
    end

    assign o_so = s.so;
    assign o_so_oe = s.so_oe;
    assign o_busy_flag = s.busy;
    assign o_write_latch = s.latch;
    assign o_sector_open_valid = s.sec_valid;
    assign o_sector_open_addr = s.sec_addr;
    assign o_row_programmed = s.row_done;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    prog_needs_latch_a: assert property ($rose(s.busy) |-> $past(s.latch) && !s.latch)
        else $error("program started without write latch");
    prog_on_cs_a: assert property ($rose(s.busy) |-> $past(cs_rise))
        else $error("program started without chip select rise");
    busy_ignore_a: assert property (s.busy && s.st == SP_OPCODE && sck_rise &&
        s.cnt == OPC_LAST_BIT && opc_new != CMD_STATUS_READ |=> s.st == SP_IGNORE)
        else $error("command accepted while busy");
    busy_length_a: assert property ($rose(s.busy) |-> s.busy_cnt == PROG_CYCLES ##1
        s.busy[*8])
        else $error("busy flag dropped early");
    ptr_wrap_a: assert property (sck_rise && s.st == SP_RUN && s.opc == CMD_OTP_ROW_PROGRAM &&
        s.cnt >= PROG_DATA_START && s.cnt[2:0] == 3'h7 && s.ptr == LAST_BYTE |=> s.ptr == 8'h00)
        else $error("page pointer did not wrap");
    row_once_a: assert property ((~s.row_done & $past(s.row_done)) == 4'h0)
        else $error("row programmed flag cleared");
    read_busy_a: assert property (i_ext_busy && s.st == SP_OPCODE && sck_rise &&
        s.cnt == OPC_LAST_BIT && opc_new == CMD_OTP_ROW_READ |=> s.st == SP_IGNORE)
        else $error("read accepted while busy");
    so_release_a: assert property (cs_rise |=> !s.so_oe ##1 !s.so_oe)
        else $error("output still driven after chip select rise");
    open_needs_bp_a: assert property ($rose(s.sec_valid) |-> i_block_protect != 4'h0)
        else $error("sector opened without block protection");
    close_relock_a: assert property (cs_rise && s.st == SP_RUN &&
        s.opc == CMD_SECTOR_CLOSE |=> !s.sec_valid)
        else $error("sector close did not relock");
    lock_blocks_a: assert property ($rose(s.busy) |-> !i_row_lock[s.prog_row])
        else $error("locked row programmed");
    // program time is fixed, so busy must span it exactly
    busy_time_a: assert property ($rose(s.busy) |-> ##199 s.busy ##1 !s.busy)
        else $error("busy flag length wrong");
    open_addr_a: assert property (cs_rise && s.st == SP_RUN &&
        s.opc == CMD_SECTOR_OPEN && s.cnt >= PROG_DATA_START && i_block_protect != 4'h0 |=>
        s.sec_valid && s.sec_addr == $past(s.addr[23:12]))
        else $error("open sector address not taken");
    read_incr_a: assert property (sck_fall && !cs_fall && s.st == SP_RUN &&
        s.opc == CMD_OTP_ROW_READ && s.cnt >= READ_DATA_START && s.cnt[2:0] == 3'h0 |=>
        s.addr[7:0] == 8'($past(s.addr[7:0]) + 8'h01))
        else $error("read address did not advance");

endmodule

// ===== design/orl_pkg.sv
// constants for the information-row program/read and sector open/close logic
// assumes one 100 MHz core clock that oversamples the serial link pins

package orl_pkg;

    // ------------------------------------------------------------------
    // command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] CMD_STATUS_READ = 8'h05;
    localparam logic [7:0] CMD_OTP_ROW_PROGRAM = 8'h62;
    localparam logic [7:0] CMD_OTP_ROW_READ = 8'h68;
    localparam logic [7:0] CMD_SECTOR_OPEN = 8'h26;
    localparam logic [7:0] CMD_SECTOR_CLOSE = 8'h24;

    // ------------------------------------------------------------------
    // information area layout
    // ------------------------------------------------------------------
    localparam int ROWS = 4;
    localparam int ROW_BYTES = 256;
    localparam logic [7:0] ROW_HIGH_BYTE = 8'h00;
    localparam logic [7:0] ROW_MID_MASK = 8'hCF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] UNDEF_BYTE = 8'hFF;
    localparam logic [7:0] LAST_BYTE = 8'hFF;

    // ------------------------------------------------------------------
    // serial frame bit positions (rising edges counted from chip select low)
    // ------------------------------------------------------------------
    localparam logic [5:0] OPC_LAST_BIT = 6'h07;
    localparam logic [5:0] STATUS_DATA_START = 6'h08;
    localparam logic [5:0] ADDR_LAST_BIT = 6'h1F;
    localparam logic [5:0] PROG_DATA_START = 6'h20;
    localparam logic [5:0] READ_DATA_START = 6'h28;

    // status byte fields
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_LATCH_BIT = 1;

    // ------------------------------------------------------------------
    // internal program time
    // ------------------------------------------------------------------
    localparam int CORE_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 2000;
    localparam logic [15:0] PROG_CYCLES =
        16'((PROG_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);

    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_OPCODE = 2'b01,
        SP_RUN = 2'b10,
        SP_IGNORE = 2'b11
    } orl_spi_e;

endpackage

// ===== verification/orl_host_model.sv
// host serial controller model: mode 0, msb first, 160 ns serial clock
// assumes a 100 MHz core clock; every pin change lands on its rising edge

module orl_host_model (
    input wire logic i_core_clk, // core clock
    input wire logic i_so, // device serial out
    input wire logic i_so_oe, // device drives serial out
    output logic o_cs_n, // chip select, active low
    output logic o_sck, // serial clock, idle low
    output logic o_si, // serial data to device
    output logic o_saw_oe // device drove out in last frame
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_saw_oe = 1'b0;
    end

    // half a serial clock period in core cycles
    task automatic half();
        repeat (8) @(posedge i_core_clk);
    endtask

    // send tx bytes, then clock in nrx bytes; clock stands still outside frames
    task automatic frame(input logic [7:0] tx[$], input int nrx, output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        o_saw_oe <= 1'b0;
        o_cs_n <= 1'b0;
        half();
        for (int i = 0; i < tx.size() + nrx; i++) begin
            b = (i < tx.size()) ? tx[i] : 8'h00;
            for (int k = 7; k >= 0; k--) begin
                // data line toggles while only reading, so no stale bit hides
                o_si <= (i < tx.size()) ? b[k] : ~o_si;
                half();
                o_sck <= 1'b1;
                if (i >= tx.size()) begin
                    // an undriven line reads inverted, so a silent device cannot match
                    b[k] = i_so_oe ? i_so : ~i_so;
                end
                if (i_so_oe) begin
                    o_saw_oe <= 1'b1;
                end
                half();
                o_sck <= 1'b0;
            end
            if (i >= tx.size()) begin
                rx.push_back(b);
            end
        end
        half();
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        half();
    endtask
endmodule

// ===== verification/orl_otp_row_and_sector_lock_tb_top.sv
// bench for the information-row and sector lock command handler
// assumes orl_host_model plays the serial host; lock inputs driven here

module orl_otp_row_and_sector_lock_tb_top import orl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ext_busy = 1'b0;
    logic [3:0] i_block_protect = 4'h0;
    logic [3:0] i_row_lock = 4'h0;
    logic cs_n, sck, si, so, so_oe, busy, latch, open_v, saw_oe;
    logic [11:0] open_a;
    logic [3:0] done;
    logic [7:0] rx[$];
    logic [7:0] q[$];
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #5 i_core_clk = ~i_core_clk;

    orl_otp_row_and_sector_lock i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_ext_busy(i_ext_busy),
        .i_block_protect(i_block_protect), .i_row_lock(i_row_lock), .o_so(so),
        .o_so_oe(so_oe), .o_busy_flag(busy), .o_write_latch(latch),
        .o_sector_open_valid(open_v), .o_sector_open_addr(open_a),
        .o_row_programmed(done));

    orl_host_model i_host (.i_core_clk(i_core_clk), .i_so(so), .i_so_oe(so_oe),
        .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_saw_oe(saw_oe));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmd(input logic [7:0] b[$], input int n);
        i_host.frame(b, n, rx);
    endtask

    task automatic prog(input logic [7:0] mid, input logic [7:0] lo, input logic [7:0] d[$]);
        cmd('{CMD_WRITE_PERMIT}, 0);
        check("latch", 1, latch);
        q = '{CMD_OTP_ROW_PROGRAM, 8'h00, mid, lo};
        q = {q, d};
        cmd(q, 0);
    endtask

    task automatic rd(input logic [7:0] mid, input logic [7:0] lo, input int n);
        cmd('{CMD_OTP_ROW_READ, 8'h00, mid, lo, 8'h00}, n);
    endtask

    // program takes 200 core cycles, so 400 is a safe bound
    task automatic wait_idle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
            @(posedge i_core_clk);
        end
        check("busy_end", 0, busy);
    endtask

    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_core_clk);
        check("latch", 0, latch);
        check("done", 0, done);
        cmd('{CMD_OTP_ROW_PROGRAM, 8'h00, 8'h10, 8'h05, 8'hAA}, 0);
        check("busy", 0, busy);
        prog(8'h00, 8'hFE, '{8'h11, 8'h22, 8'h33});
        check("busy", 1, busy);
        check("latch", 0, latch);
        i_block_protect <= 4'h1;
        // open during program must be dropped
        cmd('{CMD_SECTOR_OPEN, 8'h12, 8'h34, 8'h56}, 0);
        wait_idle();
        check("open", 0, open_v);
        check("done", 4'h1, done);
        rd(8'h00, 8'hFD, 3);
        check("rd_fd", 8'hFF, rx[0]);
        check("rd_fe", 8'h11, rx[1]);
        check("rd_ff", 8'h22, rx[2]);
        check("saw_oe", 1, saw_oe);
        check("oe_off", 0, so_oe);
        rd(8'h00, 8'h00, 2);
        check("rd_00", 8'h33, rx[0]);
        check("rd_01", 8'hFF, rx[1]);
        rd(8'h00, 8'hFF, 2);
        check("rd_end", 8'hFF, rx[1]);
        prog(8'h00, 8'hFE, '{8'h00});
        check("busy", 0, busy);
        rd(8'h00, 8'hFE, 1);
        check("rd_otp", 8'h11, rx[0]);
        i_row_lock <= 4'h8;
        prog(8'h30, 8'h00, '{8'h00});
        check("busy", 0, busy);
        i_row_lock <= 4'h0;
        prog(8'h40, 8'h00, '{8'h00});
        check("busy", 0, busy);
        check("latch", 0, latch);
        i_ext_busy <= 1'b1;
        rd(8'h00, 8'hFE, 1);
        check("ext_rd", 0, saw_oe);
        i_ext_busy <= 1'b0;
        // 257 bytes: the last one lands on offset 00 again
        q = {};
        for (int i = 0; i < 257; i++) begin
            q.push_back((i == 256) ? 8'hC3 : 8'(i));
        end
        prog(8'h20, 8'h00, q);
        // status read is the one command still taken while busy
        cmd('{CMD_STATUS_READ}, 1);
        check("st_busy", 8'h01, rx[0]);
        wait_idle();
        check("done", 4'h5, done);
        rd(8'h20, 8'h00, 2);
        check("wrap_00", 8'hC3, rx[0]);
        check("wrap_01", 8'h01, rx[1]);
        cmd('{CMD_WRITE_PERMIT}, 0);
        cmd('{CMD_STATUS_READ}, 2);
        check("st_latch", 8'h02, rx[0]);
        check("st_again", 8'h02, rx[1]);
        i_block_protect <= 4'h0;
        cmd('{CMD_SECTOR_OPEN, 8'h12, 8'h34, 8'h56}, 0);
        check("open", 0, open_v);
        i_block_protect <= 4'h4;
        cmd('{CMD_SECTOR_OPEN, 8'h12, 8'h34, 8'h56}, 0);
        check("open", 1, open_v);
        check("open_a", 12'h123, open_a);
        cmd('{CMD_SECTOR_OPEN, 8'hAB, 8'hCD, 8'hEF}, 0);
        check("open_a", 12'hABC, open_a);
        cmd('{CMD_SECTOR_CLOSE}, 0);
        check("open", 0, open_v);
        stop_test();
    end
endmodule
